// *** design/wdcfg_top.sv ***
// Purpose: watchdog with decoded enable, window and scaler settings
// Assumes: core status levels and instruction pulses are on clk
// Notes: rc clock pin passes a three-flop synchroniser
`timescale 1ns/1ns
`default_nettype none
module wdcfg_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic lowPowerRcClock,
  input wire logic sleepMode,
  input wire logic idleMode,
  input wire logic clearWdogInstr,
  input wire logic powerSaveInstr,
  input wire logic clockSwitchDone,
  output logic wdogResetReq,
  output logic wdogWake,
  output logic rcClockForceOn,
  output logic irq,
  input wire logic [wdcfg_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [wdcfg_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import wdcfg_pkg::*;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // register storage
  wdcfg_cfg_s cfg_reg;
  logic softEn_reg;
  logic [ST_W-1:0] status_reg;
  logic [ST_W-1:0] mask_reg;

  // axi write side
  logic awHeld_reg;
  logic [ADDR_W-1:0] awAddr_reg;
  logic wHeld_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic bValid_reg;
  logic [1:0] bResp_reg;
  logic doWrite;
  logic [31:0] byteMask;
  logic [31:0] wBits;

  // axi read side
  logic rValid_reg;
  logic [31:0] rData_reg;
  logic [1:0] rResp_reg;
  logic [31:0] readWord;
  logic readHit;

  // rc clock synchroniser
  logic rcSync1_reg;
  logic rcSync2_reg;
  logic rcSync3_reg;
  logic rcLevel_reg;
  logic rcTick;

  // watchdog control
  logic powerSaved;
  logic powerSaved_reg;
  logic normalExec;
  logic wdRun;
  logic softEnEff;
  logic wdClear;
  logic winFault;
  logic timeout;
  logic windowOpen;
  logic [CNT_W-1:0] wdCount;
  logic [ST_W-1:0] statusSet;
  logic [ST_W-1:0] statusClr;
  logic wdogResetReq_reg;
  logic wdogWake_reg;

  // ---------------- rc clock pin ----------------
  always_ff @(posedge clk) begin
    if (reset) begin
      rcSync1_reg <= 1'b0;
      rcSync2_reg <= 1'b0;
      rcSync3_reg <= 1'b0;
    end else begin
      rcSync1_reg <= lowPowerRcClock;
      rcSync2_reg <= rcSync1_reg;
      rcSync3_reg <= rcSync2_reg;
    end
  end

  // level moves only when second and third stages agree
  always_ff @(posedge clk) begin
    if (reset) begin
      rcLevel_reg <= 1'b0;
    end else if (rcSync2_reg == rcSync3_reg) begin
      rcLevel_reg <= rcSync3_reg;
    end
  end

  assign rcTick = rcSync2_reg && rcSync3_reg && !rcLevel_reg;

  // ---------------- enable decode ----------------
  assign powerSaved = sleepMode || idleMode;
  assign normalExec = !powerSaved;

  always_comb begin
    unique case (cfg_reg.enableMode)
      MODE_ALWAYS: begin
        wdRun = 1'b1;
        rcClockForceOn = 1'b1;
      end
      MODE_SOFT: begin
        wdRun = softEn_reg;
        rcClockForceOn = softEn_reg;
      end
      MODE_ACTIVE: begin
        wdRun = !sleepMode;
        rcClockForceOn = !sleepMode;
      end
      MODE_OFF: begin
        wdRun = 1'b0;
        rcClockForceOn = 1'b0;
      end
    endcase
  end

  // soft enable reads as off in mode 00
  assign softEnEff = (cfg_reg.enableMode == MODE_OFF) ? 1'b0 : softEn_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      powerSaved_reg <= 1'b0;
    end else begin
      powerSaved_reg <= powerSaved;
    end
  end

  // early clear in window mode is a fault
  assign winFault = clearWdogInstr && normalExec && wdRun && !windowOpen;

  assign wdClear = clockSwitchDone || powerSaveInstr || (powerSaved != powerSaved_reg)
    || (clearWdogInstr && normalExec);

  wdcfg_counter u_counter (
    .clk(clk),
    .reset(reset),
    .tick(rcTick),
    .run(wdRun),
    .clear(wdClear),
    .cfg(cfg_reg),
    .count(wdCount),
    .timeout(timeout),
    .windowOpen(windowOpen)
  );

  // ---------------- reset and wake requests ----------------
  always_ff @(posedge clk) begin
    if (reset) begin
      wdogResetReq_reg <= 1'b0;
      wdogWake_reg <= 1'b0;
    end else begin
      wdogResetReq_reg <= (timeout && normalExec) || winFault;
      wdogWake_reg <= timeout && powerSaved;
    end
  end

  assign wdogResetReq = wdogResetReq_reg;
  assign wdogWake = wdogWake_reg;

  // ---------------- status and interrupt ----------------
  always_comb begin
    statusSet = '0;
    statusSet[ST_TIMEOUT] = timeout && normalExec;
    statusSet[ST_WINFAULT] = winFault;
    statusSet[ST_WAKE] = timeout && powerSaved;
    statusClr = '0;
    if (doWrite && awAddr_reg == ADDR_STATUS) begin
      statusClr = wBits[ST_W-1:0];
    end
  end

  // a set in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (reset) begin
      status_reg <= ST_RESET;
    end else begin
      status_reg <= (status_reg & ~statusClr) | statusSet;
    end
  end

  assign irq = |(status_reg & mask_reg);

  // ---------------- axi write ----------------
  assign s_axi_awready = !awHeld_reg && !bValid_reg;
  assign s_axi_wready = !wHeld_reg && !bValid_reg;
  assign doWrite = awHeld_reg && wHeld_reg && !bValid_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      awHeld_reg <= 1'b0;
      awAddr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_reg <= 1'b1;
      awAddr_reg <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wHeld_reg <= 1'b0;
      wData_reg <= '0;
      wStrb_reg <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld_reg <= 1'b1;
      wData_reg <= s_axi_wdata;
      wStrb_reg <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeld_reg <= 1'b0;
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      byteMask[i*8 +: 8] = {8{wStrb_reg[i]}};
    end
    wBits = wData_reg & byteMask;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      bValid_reg <= 1'b0;
      bResp_reg <= RESP_OKAY;
    end else if (doWrite) begin
      bValid_reg <= 1'b1;
      unique case (awAddr_reg)
        ADDR_CONFIG, ADDR_CONTROL, ADDR_STATUS, ADDR_MASK, ADDR_COUNT: bResp_reg <= RESP_OKAY;
        default: bResp_reg <= RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      bValid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid = bValid_reg;
  assign s_axi_bresp = bResp_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_reg <= CFG_RESET;
    end else if (doWrite && awAddr_reg == ADDR_CONFIG) begin
      cfg_reg <= (cfg_reg & ~byteMask[CFG_W-1:0]) | wBits[CFG_W-1:0];
    end
  end

  // stored in every mode; mode 11 ignores a cleared bit
  always_ff @(posedge clk) begin
    if (reset) begin
      softEn_reg <= CTRL_RESET;
    end else if (doWrite && awAddr_reg == ADDR_CONTROL && wStrb_reg[0]) begin
      softEn_reg <= wData_reg[CTRL_SOFT_EN];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mask_reg <= MASK_RESET;
    end else if (doWrite && awAddr_reg == ADDR_MASK && wStrb_reg[0]) begin
      mask_reg <= wData_reg[ST_W-1:0];
    end
  end

  // ---------------- axi read ----------------
  assign s_axi_arready = !rValid_reg;

  always_comb begin
    readWord = '0;
    readHit = 1'b1;
    unique case (s_axi_araddr)
      ADDR_CONFIG: readWord[CFG_W-1:0] = cfg_reg;
      ADDR_CONTROL: readWord[CTRL_SOFT_EN] = softEnEff;
      ADDR_STATUS: readWord[ST_W-1:0] = status_reg;
      ADDR_MASK: readWord[ST_W-1:0] = mask_reg;
      ADDR_COUNT: begin
        readWord[CNT_W-1:0] = wdCount;
        readWord[COUNT_RUN_BIT] = wdRun;
      end
      default: readHit = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rValid_reg <= 1'b0;
      rData_reg <= '0;
      rResp_reg <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rValid_reg <= 1'b1;
      rData_reg <= readWord;
      rResp_reg <= readHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rValid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid = rValid_reg;
  assign s_axi_rdata = rData_reg;
  assign s_axi_rresp = rResp_reg;

  // ---------------- checks ----------------
  force_on_a: assert property (cfg_reg.enableMode == MODE_ALWAYS |-> rcClockForceOn && wdRun)
    else $error("mode 11 not forced on");
  soft_stop_a: assert property (cfg_reg.enableMode == MODE_SOFT && !softEn_reg
    |-> !wdRun && !rcClockForceOn)
    else $error("mode 10 runs without soft enable");
  active_only_a: assert property (cfg_reg.enableMode == MODE_ACTIVE
    |-> wdRun == !sleepMode)
    else $error("mode 01 run state wrong");
  off_mode_a: assert property (cfg_reg.enableMode == MODE_OFF
    |-> !wdRun && !softEnEff)
    else $error("mode 00 not off");
  nowin_fault_a: assert property (cfg_reg.windowDisable |-> !winFault)
    else $error("fault in non-window mode");
  timeout_rst_a: assert property (timeout && normalExec
    |=> wdogResetReq && status_reg[ST_TIMEOUT])
    else $error("time-out gave no reset");
  sleep_wake_a: assert property (timeout && powerSaved
    |=> wdogWake && !wdogResetReq)
    else $error("time-out in power save did not wake");
  early_clr_a: assert property (clearWdogInstr && normalExec && wdRun
    && !cfg_reg.windowDisable && !windowOpen |=> wdogResetReq ##0 status_reg[ST_WINFAULT])
    else $error("early clear not faulted");
  save_clear_a: assert property (powerSaveInstr |=> wdCount == '0)
    else $error("power save did not clear count");
  sticky_hold_a: assert property (status_reg[ST_WAKE] && !statusClr[ST_WAKE]
    |=> status_reg[ST_WAKE])
    else $error("wake flag lost");

  cov_timeout_c: cover property (timeout && normalExec);
  cov_wake_c: cover property (timeout && powerSaved);
  cov_fault_c: cover property (winFault);
  cov_irq_c: cover property (!irq ##1 irq);
endmodule : wdcfg_top
`default_nettype wire

// *** common/wdcfg_pkg.sv ***
// Purpose: constants and types for the watchdog with decoded configuration
// Assumes: 20 MHz system clock, low-power rc clock arrives as a pin
// Notes: register map reached over axi4-lite, 32-bit aligned words
// Functional notes
// - enable mode 11 keeps the watchdog always running with its rc clock forced on.
// - enable mode 10 runs or stops the watchdog by the soft enable bit.
// - enable mode 01 runs the watchdog except in sleep, so also in idle, and ignores the soft enable.
// - enable mode 00 keeps the watchdog off and the soft enable reads as off.
// - window disable 1 selects non-window mode, 0 selects window mode.
// - prescaler divides the rc clock by 128 when its select is 1, else by 32.
// - the 4-bit postscaler divides further by two to the power of its code.
// - in window mode the open window is 25, 37.5, 50 or 75 percent of the period.
// - postscaler code 0000 gives 1:1, sixteen ratios in all.
// - counter and scalers clear on reset, clock switch, power-save entry or exit and clear.
// - while enabled the watchdog counts in sleep and idle and a time-out there wakes.
package wdcfg_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_COUNT = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_ACTIVE = 2'h1;
  localparam logic [1:0] MODE_SOFT = 2'h2;
  localparam logic [1:0] MODE_ALWAYS = 2'h3;
  localparam int CFG_W = 10;
  localparam logic [CFG_W-1:0] CFG_RESET = 10'h3ff;
  localparam int CTRL_SOFT_EN = 0;
  localparam logic CTRL_RESET = 1'h0;
  localparam int ST_W = 3;
  localparam int ST_TIMEOUT = 0;
  localparam int ST_WINFAULT = 1;
  localparam int ST_WAKE = 2;
  localparam logic [ST_W-1:0] ST_RESET = 3'h0;
  localparam logic [ST_W-1:0] MASK_RESET = 3'h0;
  localparam int PRE_SHORT_LOG = 5;
  localparam int PRE_LONG_LOG = 7;
  localparam int CNT_W = 23;
  localparam int WIN_SHIFT = 3;
  localparam logic [2:0] WIN_CLOSED_25 = 3'h6;
  localparam logic [2:0] WIN_CLOSED_375 = 3'h5;
  localparam logic [2:0] WIN_CLOSED_50 = 3'h4;
  localparam logic [2:0] WIN_CLOSED_75 = 3'h2;
  localparam int COUNT_RUN_BIT = 31;
  typedef struct packed {
    logic [1:0] windowSel;
    logic [3:0] postSel;
    logic preSel;
    logic windowDisable;
    logic [1:0] enableMode;
  } wdcfg_cfg_s;
endpackage : wdcfg_pkg

// *** design/wdcfg_counter.sv ***
// Purpose: prescaler, postscaler and window compare of the watchdog
// Assumes: tick is a one-cycle pulse per rc clock rising edge
// Notes: prescaler and postscaler form one tick counter
`timescale 1ns/1ns
`default_nettype none
module wdcfg_counter (
  input wire logic clk,
  input wire logic reset,
  input wire logic tick,
  input wire logic run,
  input wire logic clear,
  input wire wdcfg_pkg::wdcfg_cfg_s cfg,
  output logic [wdcfg_pkg::CNT_W-1:0] count,
  output logic timeout,
  output logic windowOpen
);
  import wdcfg_pkg::*;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic [CNT_W-1:0] period;
  logic [CNT_W-1:0] closedEnd;
  logic [2:0] closedEighths;
  logic [4:0] shiftAmt;

  always_comb begin
    shiftAmt = 5'(cfg.postSel) + (cfg.preSel ? 5'(PRE_LONG_LOG) : 5'(PRE_SHORT_LOG));
    period = CNT_W'(1) << shiftAmt;
  end

  always_comb begin
    unique case (cfg.windowSel)
      2'h3: closedEighths = WIN_CLOSED_25;
      2'h2: closedEighths = WIN_CLOSED_375;
      2'h1: closedEighths = WIN_CLOSED_50;
      2'h0: closedEighths = WIN_CLOSED_75;
    endcase
    closedEnd = CNT_W'((period >> WIN_SHIFT) * closedEighths);
  end

  assign timeout = run && tick && (count_reg == period - CNT_W'(1));
  assign windowOpen = cfg.windowDisable || (count_reg >= closedEnd);
  assign count = count_reg;

  always_comb begin
    count_next = count_reg;
    if (clear || timeout) begin
      count_next = '0;
    end else if (run && tick) begin
      count_next = count_reg + CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  bound_cnt_a: assert property (@(posedge clk) disable iff (reset) count_reg < period)
    else $error("count beyond period");
  clear_zero_a: assert property (@(posedge clk) disable iff (reset)
    clear |=> count_reg == '0)
    else $error("clear did not zero count");
  closed_win_a: assert property (@(posedge clk) disable iff (reset)
    !cfg.windowDisable && count_reg < (period >> 1) && cfg.windowSel == 2'h1 |-> !windowOpen)
    else $error("window open too early");
endmodule : wdcfg_counter
`default_nettype wire

// *** test/wdcfg_testbench.sv ***
// Purpose: self-checking bench for the watchdog with decoded configuration
// Assumes: rc clock made here, period eight clk cycles, gated per scenario
// Notes: driver queues expectations, monitor compares at bus answers and pulses
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((e) !== (g)) begin errors++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module testbench;
  import wdcfg_pkg::*;
  logic clk, reset, lowPowerRcClock, sleepMode, idleMode;
  logic clearWdogInstr, powerSaveInstr, clockSwitchDone;
  logic wdogResetReq, wdogWake, rcClockForceOn, irq;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic rcRun;
  logic [1:0] rcPh;
  logic [15:0] tickCnt;
  logic [33:0] rdQ[$];
  logic [1:0] bQ[$];
  logic [17:0] evQ[$];
  logic [33:0] rdExp;
  logic [17:0] evExp;
  logic [1:0] bExp;
  wdcfg_cfg_s cfg;
  int errors, checked, cycles, seed, i, w;
  int thr[4] = '{8, 16, 20, 24};
  wdcfg_top i_dut (.clk(clk), .reset(reset), .lowPowerRcClock(lowPowerRcClock),
    .sleepMode(sleepMode), .idleMode(idleMode), .clearWdogInstr(clearWdogInstr),
    .powerSaveInstr(powerSaveInstr), .clockSwitchDone(clockSwitchDone),
    .wdogResetReq(wdogResetReq), .wdogWake(wdogWake), .rcClockForceOn(rcClockForceOn),
    .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  always #25 clk = !clk;
  // rc clock and count of rising edges made
  always @(posedge clk) begin
    if (rcRun) begin
      rcPh <= rcPh + 2'h1;
      if (rcPh == 2'h3) begin
        lowPowerRcClock <= !lowPowerRcClock;
        if (!lowPowerRcClock) tickCnt <= tickCnt + 16'h1;
      end
    end
  end
  // monitor of answers and pulses
  always @(posedge clk) begin
    if (rvalid && rready) begin
      rdExp = rdQ.pop_front();
      `CHK("read", rdExp, {rresp, rdata})
    end
    if (bvalid && bready) begin
      bExp = bQ.pop_front();
      `CHK("bresp", bExp, bresp)
    end
    if (wdogResetReq || wdogWake) begin
      evExp = (evQ.size() != 0) ? evQ.pop_front() : 18'h0;
      `CHK("event", evExp, {wdogWake, wdogResetReq, tickCnt})
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      errors++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, wd;
    bQ.push_back(er);
    aw = 0;
    wd = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    while (!(aw && wd)) begin
      @(posedge clk);
      if (!aw && awready) begin aw = 1; awvalid <= 0; end
      if (!wd && wready) begin wd = 1; wvalid <= 0; end
    end
    bready <= 1;
    do @(posedge clk); while (!bvalid);
    bready <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    rdQ.push_back(e);
    araddr <= a;
    arvalid <= 1;
    do @(posedge clk); while (!arready);
    arvalid <= 0;
    rready <= 1;
    do @(posedge clk); while (!rvalid);
    rready <= 0;
  endtask : rd
  task automatic pulse(input int src);
    clearWdogInstr <= (src == 0);
    powerSaveInstr <= (src == 1);
    clockSwitchDone <= (src == 2);
    @(posedge clk);
    {clearWdogInstr, powerSaveInstr, clockSwitchDone} <= 3'h0;
    @(posedge clk);
  endtask : pulse
  task automatic arm(input int src);
    pulse(src);
    tickCnt <= 16'h0;
    @(posedge clk);
  endtask : arm
  task automatic quiet(input int n);
    tickCnt <= 16'h0;
    @(posedge clk);
    rcRun <= 1;
    while (tickCnt < n) @(posedge clk);
    rcRun <= 0;
    repeat (8) @(posedge clk);
  endtask : quiet
  task automatic ev(input logic [1:0] k, input logic [15:0] t);
    evQ.push_back({k, t});
    rcRun <= 1;
    while (evQ.size() != 0) @(posedge clk);
    rcRun <= 0;
    @(posedge clk);
  endtask : ev
  task automatic wcfg();
    wr(ADDR_CONFIG, {22'h0, cfg}, RESP_OKAY);
  endtask : wcfg
  initial begin
    seed = 81;
    clk = 0;
    reset = 1;
    {lowPowerRcClock, sleepMode, idleMode, rcRun} = 4'h0;
    {clearWdogInstr, powerSaveInstr, clockSwitchDone} = 3'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    rcPh = 2'h0;
    tickCnt = 16'h0;
    repeat (12) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    `CHK("forceOn", 1'b1, rcClockForceOn)
    rd(ADDR_CONFIG, {RESP_OKAY, 22'h0, CFG_RESET});
    rd(ADDR_CONTROL, {RESP_OKAY, 32'h0});
    rd(ADDR_STATUS, {RESP_OKAY, 32'h0});
    rd(ADDR_MASK, {RESP_OKAY, 32'h0});
    rd(8'h14, {RESP_SLVERR, 32'h0});
    wr(8'h14, 32'h3, RESP_SLVERR);
    wr(ADDR_CONTROL, 32'h0, RESP_OKAY);
    cfg.windowSel = 2'h3;
    cfg.windowDisable = 1'b1;
    cfg.enableMode = MODE_ALWAYS;
    for (i = 0; i < 6; i++) begin
      cfg.preSel = (i < 3) ? 1'(i == 1) : 1'($random(seed) & 1);
      cfg.postSel = (i < 3) ? 4'(i == 2) : 4'($random(seed) & 3);
      wcfg();
      quiet(20);
      rd(ADDR_COUNT, {RESP_OKAY, 32'h80000014});
      arm(i % 3);
      ev(2'h1, 16'h1 << (5 + 2 * cfg.preSel + cfg.postSel));
    end
    rd(ADDR_STATUS, {RESP_OKAY, 32'h1});
    wr(ADDR_STATUS, 32'h7, RESP_OKAY);
    cfg.preSel = 1'b0;
    cfg.postSel = 4'h0;
    cfg.enableMode = MODE_SOFT;
    wcfg();
    quiet(48);
    `CHK("forceOn", 1'b0, rcClockForceOn)
    wr(ADDR_CONTROL, 32'h1, RESP_OKAY);
    arm(0);
    ev(2'h1, 16'd32);
    cfg.enableMode = MODE_OFF;
    wcfg();
    rd(ADDR_CONTROL, {RESP_OKAY, 32'h0});
    quiet(48);
    rd(ADDR_COUNT, {RESP_OKAY, 32'h0});
    cfg.enableMode = MODE_ACTIVE;
    wcfg();
    wr(ADDR_CONTROL, 32'h0, RESP_OKAY);
    sleepMode <= 1;
    quiet(48);
    sleepMode <= 0;
    arm(3);
    ev(2'h1, 16'd32);
    cfg.enableMode = MODE_ALWAYS;
    wcfg();
    idleMode <= 1;
    wr(ADDR_MASK, 32'h4, RESP_OKAY);
    arm(3);
    ev(2'h2, 16'd32);
    `CHK("irq", 1'b1, irq)
    rd(ADDR_STATUS, {RESP_OKAY, 32'h5});
    wr(ADDR_STATUS, 32'h4, RESP_OKAY);
    `CHK("irq", 1'b0, irq)
    rd(ADDR_STATUS, {RESP_OKAY, 32'h1});
    wr(ADDR_STATUS, 32'h1, RESP_OKAY);
    idleMode <= 0;
    wr(ADDR_MASK, 32'h0, RESP_OKAY);
    cfg.windowDisable = 1'b0;
    for (w = 0; w < 4; w++) begin
      cfg.windowSel = 2'(w);
      wcfg();
      arm(2);
      quiet(thr[w] - 1);
      evQ.push_back({2'h1, 16'(thr[w] - 1)});
      pulse(0);
      while (evQ.size() != 0) @(posedge clk);
      rd(ADDR_STATUS, {RESP_OKAY, 32'h2});
      wr(ADDR_STATUS, 32'h7, RESP_OKAY);
      quiet(thr[w]);
      arm(0);
    end
    final_report();
  end
endmodule : testbench
`default_nettype wire
